// ### gain_and_pulse_source_config.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
// How it works
// - current gain codes 0-4, others act 0
// - neutral gain resets 0, reserved act 0
// - no neutral channel: neutral gain reads 0
// - voltage gain resets 0, reserved act 0
// - gain bits 15:9 zero, no effect
// - output 1 source, resets total active
// - reserved output 1 source: no pulses
// - output 2 source, resets total reactive
// - reserved output 2 source: no pulses
// - output 3 source, resets apparent
// - reserved output 3 source: no pulses
// - disable 1 resets set, converter keeps running
// - disable 1 clear passes pulses out
// - absent quantities selected have no effect
// - per-phase inclusion bits, reset all set
// - disable 2 resets set, suppresses pin
// - disable 3 resets set, suppresses pin
module gain_and_pulse_source_config #(
	parameter bit HAS_NEUTRAL     = 1'h1,
	parameter bit HAS_REACTIVE    = 1'h1,
	parameter bit HAS_FUNDAMENTAL = 1'h1
) (
	input  wire logic                             clk,
	input  wire logic                             reset,
	input  wire logic                             clk_en,
	input  wire logic [15:0]                      reg_addr,
	input  wire logic [15:0]                      reg_wdata,
	input  wire logic                             reg_wr,
	input  wire logic                             reg_rd,
	output logic [15:0]                           reg_rdata,
	input  wire logic                             calc_strobe,
	input  wire logic [3*meter_cfg_pkg::PWR_W-1:0] power_active,
	input  wire logic [3*meter_cfg_pkg::PWR_W-1:0] power_reactive,
	input  wire logic [3*meter_cfg_pkg::PWR_W-1:0] power_apparent,
	input  wire logic [3*meter_cfg_pkg::PWR_W-1:0] power_fund_active,
	input  wire logic [3*meter_cfg_pkg::PWR_W-1:0] power_fund_reactive,
	input  wire logic [2:0]                       dfc_pulse,
	output logic [2:0]                            phase_current_gain_sel,
	output logic [2:0]                            neutral_current_gain_sel,
	output logic [2:0]                            phase_voltage_gain_sel,
	output logic [meter_cfg_pkg::SUM_W-1:0]       pulse1_sum,
	output logic [meter_cfg_pkg::SUM_W-1:0]       pulse2_sum,
	output logic [meter_cfg_pkg::SUM_W-1:0]       pulse3_sum,
	output logic [2:0]                            dfc_run,
	output logic                                  pulse_out_1,
	output logic                                  pulse_out_2,
	output logic                                  pulse_out_3
);
	localparam int W = meter_cfg_pkg::PWR_W;
	localparam int S = meter_cfg_pkg::SUM_W;
	localparam int F = meter_cfg_pkg::FIELD_W;

	function automatic logic [2:0] gain_eff(input logic [2:0] code);
		gain_eff = (code > meter_cfg_pkg::GAIN_CODE_MAX) ? 3'h0 : code;
	endfunction

	logic [15:0] gain_reg;
	logic [15:0] gain_next;
	logic [15:0] pulse_mode_reg;
	logic [15:0] pulse_mode_next;
	logic [15:0] comp_mode_reg;
	logic [15:0] comp_mode_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic [2:0]  igain_reg;
	logic [2:0]  ngain_reg;
	logic [2:0]  vgain_reg;
	logic [2:0]  pulse_out_reg;
	logic [2:0]  pulse_out_next;
	logic [S-1:0] sum_reg [3];
	logic [2:0]  run_reg;

	wire         sel_gain;
	wire         sel_mode;
	wire         sel_comp;
	wire [15:0]  gain_mask;
	wire [15:0]  rd_value;
	wire [3*W-1:0] react_in;
	wire [3*W-1:0] fact_in;
	wire [3*W-1:0] freact_in;

	// register decode
	assign sel_gain = (reg_addr == meter_cfg_pkg::GAIN_ADDR);
	assign sel_mode = (reg_addr == meter_cfg_pkg::PULSE_MODE_ADDR);
	assign sel_comp = (reg_addr == meter_cfg_pkg::COMP_MODE_ADDR);

	// neutral field never stores on parts without the channel
	assign gain_mask = HAS_NEUTRAL ? meter_cfg_pkg::GAIN_MASK
		: meter_cfg_pkg::GAIN_MASK_NO_N;

	// unused high bits never store, so they read zero
	assign gain_next = (reg_wr && sel_gain) ?
		(reg_wdata & gain_mask) : gain_reg;
	assign pulse_mode_next = (reg_wr && sel_mode) ?
		(reg_wdata & meter_cfg_pkg::PULSE_MODE_MASK) : pulse_mode_reg;
	assign comp_mode_next = (reg_wr && sel_comp) ?
		(reg_wdata & meter_cfg_pkg::COMP_MODE_MASK) : comp_mode_reg;

	assign rd_value = sel_gain ? gain_reg :
		sel_mode ? pulse_mode_reg :
		sel_comp ? comp_mode_reg : 16'h0000;
	// read data only in the cycle after the strobe
	assign rdata_next = reg_rd ? rd_value : 16'h0000;

	// missing quantities look like zero power
	assign react_in  = HAS_REACTIVE ? power_reactive : '0;
	assign fact_in   = HAS_FUNDAMENTAL ? power_fund_active : '0;
	assign freact_in = HAS_FUNDAMENTAL ? power_fund_reactive : '0;

	always_ff @(posedge clk) begin
		if (reset) begin
			gain_reg       <= meter_cfg_pkg::GAIN_RST;
			pulse_mode_reg <= meter_cfg_pkg::PULSE_MODE_RST;
			comp_mode_reg  <= meter_cfg_pkg::COMP_MODE_RST;
			rdata_reg      <= 16'h0000;
		end else if (clk_en) begin
			gain_reg       <= gain_next;
			pulse_mode_reg <= pulse_mode_next;
			comp_mode_reg  <= comp_mode_next;
			rdata_reg      <= rdata_next;
		end
	end

	// gains follow the register only at a computation tick
	always_ff @(posedge clk) begin
		if (reset) begin
			igain_reg <= 3'h0;
			ngain_reg <= 3'h0;
			vgain_reg <= 3'h0;
		end else if (clk_en && calc_strobe) begin
			igain_reg <= gain_eff(gain_reg[meter_cfg_pkg::IGAIN_LSB +: F]);
			ngain_reg <= gain_eff(gain_reg[meter_cfg_pkg::NGAIN_LSB +: F]);
			vgain_reg <= gain_eff(gain_reg[meter_cfg_pkg::VGAIN_LSB +: F]);
		end
	end

	genvar k;
	generate
		for (k = 0; k < 3; k++) begin : g_out
			wire [2:0] src_sel;
			wire [2:0] incl;
			wire       out_dis;

			assign src_sel = pulse_mode_reg[meter_cfg_pkg::SRC_LSB + k*F +: F];
			assign incl    = comp_mode_reg[meter_cfg_pkg::INCL_LSB + k*F +: F];
			assign out_dis = pulse_mode_reg[meter_cfg_pkg::DIS_LSB + k];

			pulse_source_mux u_mux (
				.clk           (clk),
				.reset         (reset),
				.clk_en        (clk_en),
				.calc_strobe   (calc_strobe),
				.source_sel    (src_sel),
				.phase_include (incl),
				.p_act         (power_active),
				.p_react       (react_in),
				.p_app         (power_apparent),
				.p_fact        (fact_in),
				.p_freact      (freact_in),
				.sum_reg       (sum_reg[k]),
				.run_reg       (run_reg[k])
			);

			// disable gates only the pin; the converter keeps its run
			assign pulse_out_next[k] = dfc_pulse[k] && run_reg[k] &&
				!out_dis;

			property p_dis_gate;
				@(posedge clk) disable iff (reset)
				clk_en && out_dis |=> !pulse_out_reg[k];
			endproperty
			a_dis_gate: assert property (p_dis_gate)
				else $error("disabled pulse output fired");

			property p_run_free;
				@(posedge clk) disable iff (reset)
				clk_en && calc_strobe && out_dis && src_sel < 3'h5
				|=> run_reg[k];
			endproperty
			a_run_free: assert property (p_run_free)
				else $error("converter stopped by output disable");

			property p_pass;
				@(posedge clk) disable iff (reset)
				clk_en && !out_dis && run_reg[k] && dfc_pulse[k]
				|=> pulse_out_reg[k];
			endproperty
			a_pass: assert property (p_pass)
				else $error("enabled pulse output dropped a pulse");

			property p_reserved_quiet;
				@(posedge clk) disable iff (reset)
				clk_en && calc_strobe && src_sel > 3'h4
				|=> clk_en |=> !pulse_out_reg[k];
			endproperty
			a_reserved_quiet: assert property (p_reserved_quiet)
				else $error("pulse seen with reserved source");
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (reset) begin
			pulse_out_reg <= 3'h0;
		end else if (clk_en) begin
			pulse_out_reg <= pulse_out_next;
		end
	end

	assign reg_rdata                = rdata_reg;
	assign phase_current_gain_sel   = igain_reg;
	assign neutral_current_gain_sel = ngain_reg;
	assign phase_voltage_gain_sel   = vgain_reg;
	assign pulse1_sum               = sum_reg[0];
	assign pulse2_sum               = sum_reg[1];
	assign pulse3_sum               = sum_reg[2];
	assign dfc_run                  = run_reg;
	assign pulse_out_1              = pulse_out_reg[0];
	assign pulse_out_2              = pulse_out_reg[1];
	assign pulse_out_3              = pulse_out_reg[2];

	property p_reset_values;
		@(posedge clk)
		$past(reset) |-> gain_reg == 16'h0000 &&
			pulse_mode_reg == 16'h0E88 && comp_mode_reg == 16'h01FF;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("configuration reset value wrong");

	property p_reset_sources;
		@(posedge clk)
		$past(reset) |-> pulse_mode_reg[8:0] == 9'h088 &&
			pulse_mode_reg[11:9] == 3'h7;
	endproperty
	a_reset_sources: assert property (p_reset_sources)
		else $error("pulse source or disable reset wrong");

	property p_igain_reserved;
		@(posedge clk) disable iff (reset)
		clk_en && calc_strobe && gain_reg[2:0] > 3'h4
		|=> phase_current_gain_sel == 3'h0;
	endproperty
	a_igain_reserved: assert property (p_igain_reserved)
		else $error("reserved current gain not treated as unity");

	property p_igain_valid;
		@(posedge clk) disable iff (reset)
		clk_en && calc_strobe && gain_reg[2:0] < 3'h5
		|=> phase_current_gain_sel == $past(gain_reg[2:0]);
	endproperty
	a_igain_valid: assert property (p_igain_valid)
		else $error("current gain not applied");

	property p_ngain;
		@(posedge clk) disable iff (reset)
		clk_en && calc_strobe |=> neutral_current_gain_sel ==
			($past(gain_reg[5:3]) > 3'h4 ? 3'h0 : $past(gain_reg[5:3]));
	endproperty
	a_ngain: assert property (p_ngain)
		else $error("neutral gain decode wrong");

	property p_no_neutral;
		@(posedge clk) disable iff (reset)
		!HAS_NEUTRAL |-> gain_reg[5:3] == 3'h0;
	endproperty
	a_no_neutral: assert property (p_no_neutral)
		else $error("neutral gain stored without channel");

	property p_vgain_late;
		@(posedge clk) disable iff (reset)
		clk_en && reg_wr && sel_gain && !calc_strobe ##1 !calc_strobe
		|=> $stable(phase_voltage_gain_sel);
	endproperty
	a_vgain_late: assert property (p_vgain_late)
		else $error("voltage gain changed before computation tick");

	property p_high_zero;
		@(posedge clk) disable iff (reset)
		clk_en && reg_rd && sel_gain |=> reg_rdata[15:9] == 7'h00;
	endproperty
	a_high_zero: assert property (p_high_zero)
		else $error("gain reserved bits read nonzero");

	property p_rd_once;
		@(posedge clk) disable iff (reset)
		clk_en && !reg_rd |=> reg_rdata == 16'h0000;
	endproperty
	a_rd_once: assert property (p_rd_once)
		else $error("read data stood without a read");

	property p_igain_hold;
		@(posedge clk) disable iff (reset)
		!(clk_en && calc_strobe) |=> $stable(phase_current_gain_sel) &&
			$stable(neutral_current_gain_sel) &&
			$stable(phase_voltage_gain_sel);
	endproperty
	a_igain_hold: assert property (p_igain_hold)
		else $error("gain changed outside computation tick");

	property p_mode_store;
		@(posedge clk) disable iff (reset)
		clk_en && reg_wr && sel_mode |=>
			pulse_mode_reg == ($past(reg_wdata) & 16'h0FFF);
	endproperty
	a_mode_store: assert property (p_mode_store)
		else $error("pulse mode write not stored");

	property p_comp_store;
		@(posedge clk) disable iff (reset)
		clk_en && reg_wr && sel_comp |=>
			comp_mode_reg == ($past(reg_wdata) & 16'h01FF);
	endproperty
	a_comp_store: assert property (p_comp_store)
		else $error("phase inclusion write not stored");

	property p_gain_store;
		@(posedge clk) disable iff (reset)
		clk_en && reg_wr && sel_gain |=>
			gain_reg[15:9] == 7'h00 &&
			gain_reg[2:0] == $past(reg_wdata[2:0]);
	endproperty
	a_gain_store: assert property (p_gain_store)
		else $error("gain write not stored as masked");

	property p_rd_unmapped;
		@(posedge clk) disable iff (reset)
		clk_en && reg_rd && !sel_gain && !sel_mode && !sel_comp
		|=> reg_rdata == 16'h0000;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped)
		else $error("unmapped address read nonzero");

	// reset still wins while the enable is low
	property p_freeze;
		@(posedge clk) disable iff (reset)
		!clk_en |=> $stable(gain_reg) && $stable(pulse_mode_reg) &&
			$stable(comp_mode_reg) && $stable(reg_rdata);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while clock enable low");

	property p_run_after_reset;
		@(posedge clk)
		$past(reset) |-> dfc_run == 3'h0 && pulse_out_reg == 3'h0;
	endproperty
	a_run_after_reset: assert property (p_run_after_reset)
		else $error("converter or pin active straight after reset");

	c_write_then_tick: cover property (@(posedge clk) disable iff (reset)
		clk_en && reg_wr && sel_mode ##[1:8] clk_en && calc_strobe);
	c_pulse_out: cover property (@(posedge clk) disable iff (reset)
		pulse_out_1 && pulse_out_2 && pulse_out_3);
	c_reserved_src: cover property (@(posedge clk) disable iff (reset)
		clk_en && calc_strobe && pulse_mode_reg[8:6] > 3'h4);
	c_readback: cover property (@(posedge clk) disable iff (reset)
		clk_en && reg_wr && sel_gain ##[1:4] clk_en && reg_rd && sel_gain);
	c_frozen_write: cover property (@(posedge clk) disable iff (reset)
		!clk_en && reg_wr);
endmodule

// ### gain_and_pulse_source_config_tb_top.sv
`timescale 1ns/1ps
module gain_and_pulse_source_config_tb_top;
	localparam int W = meter_cfg_pkg::SUM_W;
	logic                clk;
	logic                reset;
	logic                clk_en;
	logic                reg_wr;
	logic                reg_rd;
	logic                calc_strobe;
	logic [15:0]         reg_addr;
	logic [15:0]         reg_wdata;
	logic [15:0]         reg_rdata;
	logic [15:0]         rdata2;
	logic [15:0]         rd_val;
	logic [15:0]         rd_val2;
	logic [71:0]         p_bus [5];
	logic signed [23:0]  pw [5][3];
	logic [2:0]          dfc_pulse;
	logic [2:0]          igain;
	logic [2:0]          ngain;
	logic [2:0]          vgain;
	logic [2:0]          ngain2;
	logic [2:0]          dfc_run;
	logic [2:0]          dfc_run2;
	logic [W-1:0]        sum1;
	logic [W-1:0]        sum2;
	logic [W-1:0]        sum3;
	logic [W-1:0]        sum1_b;
	logic [2:0]          pouts;
	int                  n_fail;
	int                  cmp_count;

	gain_and_pulse_source_config dut (
		.clk(clk), .reset(reset), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .calc_strobe(calc_strobe),
		.power_active(p_bus[0]), .power_reactive(p_bus[1]),
		.power_apparent(p_bus[2]), .power_fund_active(p_bus[3]),
		.power_fund_reactive(p_bus[4]), .dfc_pulse(dfc_pulse),
		.phase_current_gain_sel(igain), .neutral_current_gain_sel(ngain),
		.phase_voltage_gain_sel(vgain), .pulse1_sum(sum1),
		.pulse2_sum(sum2), .pulse3_sum(sum3), .dfc_run(dfc_run),
		.pulse_out_1(pouts[0]), .pulse_out_2(pouts[1]),
		.pulse_out_3(pouts[2])
	);

	// reduced variant: no neutral, reactive or fundamental measurement
	gain_and_pulse_source_config #(
		.HAS_NEUTRAL(1'h0), .HAS_REACTIVE(1'h0), .HAS_FUNDAMENTAL(1'h0)
	) dut_lite (
		.clk(clk), .reset(reset), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(rdata2), .calc_strobe(calc_strobe),
		.power_active(p_bus[0]), .power_reactive(p_bus[1]),
		.power_apparent(p_bus[2]), .power_fund_active(p_bus[3]),
		.power_fund_reactive(p_bus[4]), .dfc_pulse(dfc_pulse),
		.phase_current_gain_sel(), .neutral_current_gain_sel(ngain2),
		.phase_voltage_gain_sel(), .pulse1_sum(sum1_b),
		.pulse2_sum(), .pulse3_sum(), .dfc_run(dfc_run2),
		.pulse_out_1(), .pulse_out_2(), .pulse_out_3()
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [W-1:0] exp_sum(input int s,
		input logic [2:0] inc, input bit on);
		logic [W-1:0] acc;
		acc = '0;
		if (s < 5 && on) begin
			for (int p = 0; p < 3; p++) begin
				if (inc[p]) begin
					acc = acc + W'(pw[s][p]);
				end
			end
		end
		return acc;
	endfunction

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t reg read %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_sum(input logic [W-1:0] g, input logic [W-1:0] e);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t sum %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_bits(input logic [2:0] g, input logic [2:0] e);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t bits %b exp %b", $time, g, e);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	// data stands only in the cycle after the strobe, so sample there
	task automatic rd(input logic [15:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		rd_val = reg_rdata;
		rd_val2 = rdata2;
	endtask

	task automatic tick();
		@(posedge clk);
		calc_strobe <= 1'b1;
		@(posedge clk);
		calc_strobe <= 1'b0;
		#1;
	endtask

	task automatic pulse(input logic [2:0] v);
		@(posedge clk);
		dfc_pulse <= v;
		@(posedge clk);
		dfc_pulse <= 3'h0;
		#1;
	endtask

	// whole run is about 150 cycles; this is a wide margin
	initial begin
		#20000;
		n_fail++;
		results();
	end

	initial begin
		logic [2:0]  cc;
		logic [2:0]  e;
		logic [2:0]  prev;
		logic [15:0] g;
		reset = 1'b1;
		clk_en = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		calc_strobe = 1'b0;
		dfc_pulse = 3'h0;
		prev = 3'h0;
		// phase b negative so sign extension shows in the sums
		for (int s = 0; s < 5; s++) begin
			for (int p = 0; p < 3; p++) begin
				pw[s][p] = 24'((p == 1) ? -((s+1)*1000+p) : (s+1)*1000+p*3);
				p_bus[s][24*p +: 24] = pw[s][p];
			end
		end
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		rd(meter_cfg_pkg::GAIN_ADDR);
		chk_reg(rd_val, 16'h0000);
		rd(meter_cfg_pkg::PULSE_MODE_ADDR);
		chk_reg(rd_val, 16'h0E88);
		rd(meter_cfg_pkg::COMP_MODE_ADDR);
		chk_reg(rd_val, 16'h01FF);
		rd(16'hE611);
		chk_reg(rd_val, 16'h0000);
		tick();
		chk_sum(sum1, exp_sum(0, 3'h7, 1'b1));
		chk_sum(sum2, exp_sum(1, 3'h7, 1'b1));
		chk_sum(sum3, exp_sum(2, 3'h7, 1'b1));
		chk_bits(dfc_run, 3'h7);
		pulse(3'h7);
		chk_bits(pouts, 3'h0);
		wr(meter_cfg_pkg::PULSE_MODE_ADDR, 16'h0C88);
		tick();
		pulse(3'h7);
		chk_bits(pouts, 3'h1);
		for (int c = 0; c < 8; c++) begin
			cc = c[2:0];
			g = {7'h00, cc, cc, cc};
			e = (c <= 4) ? cc : 3'h0;
			wr(meter_cfg_pkg::GAIN_ADDR, g | 16'hFE00);
			chk_bits(igain, prev);
			rd(meter_cfg_pkg::GAIN_ADDR);
			chk_reg(rd_val, g);
			chk_reg(rd_val2, g & 16'h01C7);
			tick();
			chk_bits(igain, e);
			chk_bits(ngain, e);
			chk_bits(vgain, e);
			chk_bits(ngain2, 3'h0);
			prev = e;
		end
		for (int c = 0; c < 8; c++) begin
			cc = c[2:0];
			e = (c <= 4) ? 3'h7 : 3'h0;
			wr(meter_cfg_pkg::PULSE_MODE_ADDR, {7'h00, cc, cc, cc});
			tick();
			chk_bits(dfc_run, e);
			chk_bits(dfc_run2, e);
			chk_sum(sum1, exp_sum(c, 3'h7, 1'b1));
			chk_sum(sum2, exp_sum(c, 3'h7, 1'b1));
			chk_sum(sum3, exp_sum(c, 3'h7, 1'b1));
			chk_sum(sum1_b, exp_sum(c, 3'h7, c == 0 || c == 2));
			pulse(3'h7);
			chk_bits(pouts, e);
		end
		wr(meter_cfg_pkg::COMP_MODE_ADDR, 16'h0031);
		wr(meter_cfg_pkg::PULSE_MODE_ADDR, 16'h0088);
		tick();
		rd(meter_cfg_pkg::COMP_MODE_ADDR);
		chk_reg(rd_val, 16'h0031);
		chk_sum(sum1, exp_sum(0, 3'h1, 1'b1));
		chk_sum(sum2, exp_sum(1, 3'h6, 1'b1));
		chk_sum(sum3, exp_sum(2, 3'h0, 1'b1));
		// frozen enable: neither write nor tick may land
		@(posedge clk);
		clk_en <= 1'b0;
		wr(meter_cfg_pkg::GAIN_ADDR, 16'h0004);
		tick();
		chk_bits(igain, 3'h0);
		@(posedge clk);
		clk_en <= 1'b1;
		rd(meter_cfg_pkg::GAIN_ADDR);
		chk_reg(rd_val, 16'h01FF);
		// mid-run reset restores defaults, disables set again
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk_bits(igain, 3'h0);
		chk_bits(dfc_run, 3'h0);
		rd(meter_cfg_pkg::GAIN_ADDR);
		chk_reg(rd_val, 16'h0000);
		rd(meter_cfg_pkg::PULSE_MODE_ADDR);
		chk_reg(rd_val, 16'h0E88);
		rd(meter_cfg_pkg::COMP_MODE_ADDR);
		chk_reg(rd_val, 16'h01FF);
		tick();
		chk_bits(dfc_run, 3'h7);
		chk_sum(sum1, exp_sum(0, 3'h7, 1'b1));
		pulse(3'h7);
		chk_bits(pouts, 3'h0);
		results();
	end
endmodule

// ### meter_cfg_pkg.sv
package meter_cfg_pkg;
	localparam int PWR_W = 24;
	localparam int SUM_W = 26;
	localparam int FIELD_W = 3;
	localparam int PHASES = 3;
	localparam int OUTPUTS = 3;

	localparam logic [15:0] COMP_MODE_ADDR  = 16'hE60E;
	localparam logic [15:0] GAIN_ADDR       = 16'hE60F;
	localparam logic [15:0] PULSE_MODE_ADDR = 16'hE610;

	localparam int IGAIN_LSB = 0;
	localparam int NGAIN_LSB = 3;
	localparam int VGAIN_LSB = 6;
	localparam int SRC_LSB   = 0;
	localparam int INCL_LSB  = 0;
	localparam int DIS_LSB   = 9;

	localparam logic [15:0] GAIN_RST       = 16'h0000;
	localparam logic [15:0] PULSE_MODE_RST = 16'h0E88;
	localparam logic [15:0] COMP_MODE_RST  = 16'h01FF;

	localparam logic [15:0] GAIN_MASK       = 16'h01FF;
	localparam logic [15:0] GAIN_MASK_NO_N  = 16'h01C7;
	localparam logic [15:0] PULSE_MODE_MASK = 16'h0FFF;
	localparam logic [15:0] COMP_MODE_MASK  = 16'h01FF;

	localparam logic [2:0] GAIN_CODE_MAX = 3'h4;
	localparam logic [2:0] INCL_ALL      = 3'h7;

	typedef enum logic [2:0] {
		SRC_ACTIVE       = 3'h0,
		SRC_REACTIVE     = 3'h1,
		SRC_APPARENT     = 3'h2,
		SRC_FUND_ACTIVE  = 3'h3,
		SRC_FUND_REACT   = 3'h4
	} src_t;
endpackage

// ### pulse_source_mux.sv
`timescale 1ns/1ps
module pulse_source_mux (
	input  wire logic                             clk,
	input  wire logic                             reset,
	input  wire logic                             clk_en,
	input  wire logic                             calc_strobe,
	input  wire logic [2:0]                       source_sel,
	input  wire logic [2:0]                       phase_include,
	input  wire logic [3*meter_cfg_pkg::PWR_W-1:0] p_act,
	input  wire logic [3*meter_cfg_pkg::PWR_W-1:0] p_react,
	input  wire logic [3*meter_cfg_pkg::PWR_W-1:0] p_app,
	input  wire logic [3*meter_cfg_pkg::PWR_W-1:0] p_fact,
	input  wire logic [3*meter_cfg_pkg::PWR_W-1:0] p_freact,
	output logic [meter_cfg_pkg::SUM_W-1:0]       sum_reg,
	output logic                                  run_reg
);
	localparam int W = meter_cfg_pkg::PWR_W;
	localparam int S = meter_cfg_pkg::SUM_W;

	wire [3*W-1:0] chosen;
	wire           run_next;
	wire [S-1:0]   term [3];
	wire [S-1:0]   sum_next;

	assign chosen =
		(source_sel == meter_cfg_pkg::SRC_ACTIVE)      ? p_act :
		(source_sel == meter_cfg_pkg::SRC_REACTIVE)    ? p_react :
		(source_sel == meter_cfg_pkg::SRC_APPARENT)    ? p_app :
		(source_sel == meter_cfg_pkg::SRC_FUND_ACTIVE) ? p_fact :
		(source_sel == meter_cfg_pkg::SRC_FUND_REACT)  ? p_freact :
		'0;
	// reserved codes stop the converter entirely
	assign run_next = (source_sel <= meter_cfg_pkg::SRC_FUND_REACT);

	genvar p;
	generate
		for (p = 0; p < 3; p++) begin : g_phase
			// excluded phases add nothing
			assign term[p] = phase_include[p] ?
				{{(S-W){chosen[p*W+W-1]}}, chosen[p*W +: W]} : '0;
		end
	endgenerate

	assign sum_next = term[0] + term[1] + term[2];

	// sampled only at the computation tick, so writes land there
	always_ff @(posedge clk) begin
		if (reset) begin
			sum_reg <= '0;
			run_reg <= 1'h0;
		end else if (clk_en && calc_strobe) begin
			sum_reg <= sum_next;
			run_reg <= run_next;
		end
	end

	property p_reserved_stops;
		@(posedge clk) disable iff (reset)
		clk_en && calc_strobe && source_sel > 3'h4 |=> !run_reg;
	endproperty
	a_reserved_stops: assert property (p_reserved_stops)
		else $error("reserved source left converter running");

	property p_none_included;
		@(posedge clk) disable iff (reset)
		clk_en && calc_strobe && phase_include == 3'h0 |=> sum_reg == '0;
	endproperty
	a_none_included: assert property (p_none_included)
		else $error("sum nonzero with no phase included");

	property p_phase_a_active;
		@(posedge clk) disable iff (reset)
		clk_en && calc_strobe && source_sel == 3'h0 &&
			phase_include == 3'h1
		|=> sum_reg == {{(S-W){$past(p_act[W-1])}}, $past(p_act[W-1:0])};
	endproperty
	a_phase_a_active: assert property (p_phase_a_active)
		else $error("active sum of phase A wrong");

	property p_hold_between;
		@(posedge clk) disable iff (reset)
		!(clk_en && calc_strobe) |=> $stable(sum_reg) && $stable(run_reg);
	endproperty
	a_hold_between: assert property (p_hold_between)
		else $error("sum changed outside computation tick");
endmodule
